//--- src/global_regs_pkg.sv
// Constants, field layout and carrier types for the global register bank
package global_regs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_ID = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PINCTL = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 5'h12;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT_LATCH = 5'h16;
  localparam logic [ADDR_W-1:0] OFS_STAT_EN = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_READ = 5'h1c;

  localparam logic [DATA_W-1:0] CTRL1_RESET = 16'h0002;
  localparam logic [DATA_W-1:0] CTRL1_MASK = 16'h40ff;
  localparam logic [DATA_W-1:0] CTRL1_FULL_MASK = 16'h0001;
  localparam logic [DATA_W-1:0] CTRL2_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL2_MASK = 16'h0f0e;
  localparam logic [DATA_W-1:0] PINCTL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  localparam logic [1:0] PM_MODE_BIT = 2'h0;
  localparam logic [1:0] PM_MODE_PIN = 2'h1;

  localparam int GENERAL_PIN_SIX_IDX = 5;
  localparam int PM_PIN_IDX = 7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 100;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic unused_15;
    logic irq_idle_drive_select;
    logic [5:0] unused_13_8;
    logic manual_error_insert_trigger;
    logic error_insert_source_select;
    logic [1:0] pm_update_mode;
    logic pm_update_bit;
    logic latched_clear_on_read_select;
    logic datapath_soft_reset;
    logic full_soft_reset;
  } ctrl1_t;

endpackage

//--- src/bit_sync.sv
// Two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/10ps
module bit_sync
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

//--- src/sticky_bits.sv
// Sticky status bits where a set in the same cycle beats any clear
`timescale 1ns/10ps
module sticky_bits
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Set, clear and forced clear
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic force_clear,
  output logic [WIDTH-1:0] held_bits
);

  logic [WIDTH-1:0] held_reg;
  logic [WIDTH-1:0] held_next;

  // Even a forced clear keeps an event of this very cycle
  assign held_next = force_clear ? set_bits : ((held_reg & ~clear_bits) | set_bits);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      held_reg <= '0;
    else
      held_reg <= held_next;
  end

  assign held_bits = held_reg;

endmodule

//--- src/global_control_registers.sv
// Global register bank: identity, controls, interrupt and status words
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module global_control_registers
  import global_regs_pkg::*;
#(
  // Arbitrary identity values
  parameter logic [3:0] REVISION_CODE = 4'h1,
  parameter logic [11:0] PART_CODE = 12'h5a5,
  parameter int PIN_COUNT = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire reg_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  // Event and status sources
  input wire logic [DATA_W-1:0] irq_source,
  input wire logic [DATA_W-1:0] status_in,
  input wire logic one_second_tick,
  // General purpose pins
  input wire logic [PIN_COUNT-1:0] general_pin_in,
  // Control outputs
  output logic [DATA_W-1:0] control_two,
  output logic [DATA_W-1:0] pin_control,
  output logic latched_clear_on_read_select,
  output logic global_error_insert,
  output logic pm_update,
  output logic datapath_reset,
  output logic full_reset,
  // Identity towards the boundary-scan block
  output logic [3:0] revision_code_bits,
  output logic [11:0] part_code_bits,
  // Interrupt
  output logic irq,
  output logic irq_pin_out,
  output logic irq_pin_oe
);

  localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(RESET_HOLD_CYCLES);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);

  // Edge detect shared by trigger paths
  function automatic logic rising(input logic prev, input logic cur);
    rising = cur & ~prev;
  endfunction

  // Reset is asserted for the request and until the minimum has elapsed
  function automatic logic hold_active(input logic req, input logic [HOLD_W-1:0] cnt);
    hold_active = req | ((cnt != HOLD_ZERO) & (cnt != HOLD_MAX));
  endfunction

  function automatic logic [HOLD_W-1:0] hold_next(input logic req,
                                                 input logic [HOLD_W-1:0] cnt);
    if (!hold_active(req, cnt))
      hold_next = HOLD_ZERO;
    else if (cnt == HOLD_MAX)
      hold_next = cnt;
    else
      hold_next = cnt + HOLD_ONE;
  endfunction

  // Registers
  logic [DATA_W-1:0] ctrl1_reg;
  logic [DATA_W-1:0] ctrl1_next;
  logic [DATA_W-1:0] ctrl2_reg;
  logic [DATA_W-1:0] ctrl2_next;
  logic [DATA_W-1:0] pinctl_reg;
  logic [DATA_W-1:0] pinctl_next;
  logic [DATA_W-1:0] irq_en_reg;
  logic [DATA_W-1:0] irq_en_next;
  logic [DATA_W-1:0] stat_en_reg;
  logic [DATA_W-1:0] stat_en_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] status_prev_reg;
  logic [HOLD_W-1:0] dp_hold_reg;
  logic [HOLD_W-1:0] full_hold_reg;
  logic trig_prev_reg;
  logic pin_six_prev_reg;
  logic pm_bit_prev_reg;
  logic pm_pin_prev_reg;
  logic err_pulse_reg;
  logic pm_pulse_reg;
  logic irq_reg;
  logic irq_next;

  // Decoded fields and strobes
  ctrl1_t ctrl1;
  logic [PIN_COUNT-1:0] pins_sync;
  logic [DATA_W-1:0] pin_word;
  logic [DATA_W-1:0] id_word;
  logic [DATA_W-1:0] latched_bits;
  logic [DATA_W-1:0] latched_set;
  logic [DATA_W-1:0] latched_clear;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] ctrl1_written;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_pinctl;
  logic wr_irq_en;
  logic wr_stat_en;
  logic wr_latch;
  logic rd_latch;
  logic full_active;
  logic dp_active;
  logic pin_six;
  logic pm_pin;
  logic err_fire;
  logic pm_fire;

  assign ctrl1 = ctrl1_t'(ctrl1_reg);

  // Pins come from outside the clock domain
  bit_sync #(
    .WIDTH(PIN_COUNT)
  ) pin_sync_inst (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(general_pin_in),
    .sync_out(pins_sync)
  );

  assign pin_six = pins_sync[GENERAL_PIN_SIX_IDX];
  assign pm_pin = pins_sync[PM_PIN_IDX];
  assign pin_word = {{(DATA_W-PIN_COUNT){1'b0}}, pins_sync};

  // Address decode
  assign wr_ctrl1 = reg_req.wr & (reg_req.addr == OFS_CTRL1);
  assign wr_ctrl2 = reg_req.wr & (reg_req.addr == OFS_CTRL2);
  assign wr_pinctl = reg_req.wr & (reg_req.addr == OFS_PINCTL);
  assign wr_irq_en = reg_req.wr & (reg_req.addr == OFS_IRQ_EN);
  assign wr_stat_en = reg_req.wr & (reg_req.addr == OFS_STAT_EN);
  assign wr_latch = reg_req.wr & (reg_req.addr == OFS_STAT_LATCH);
  assign rd_latch = reg_req.rd & (reg_req.addr == OFS_STAT_LATCH);

  // Reset stretchers enforce the minimum even if the host clears early
  assign full_active = hold_active(ctrl1.full_soft_reset, full_hold_reg);
  assign dp_active = hold_active(ctrl1.datapath_soft_reset, dp_hold_reg) | full_active;

  // Control one: full reset returns all but its own bit to default
  assign ctrl1_written = wr_ctrl1 ? (reg_req.wdata & CTRL1_MASK) : ctrl1_reg;
  assign ctrl1_next = full_active ?
                      ((CTRL1_RESET & ~CTRL1_FULL_MASK) | (ctrl1_written & CTRL1_FULL_MASK)) :
                      ctrl1_written;

  assign ctrl2_next = full_active ? CTRL2_RESET :
                      (wr_ctrl2 ? (reg_req.wdata & CTRL2_MASK) : ctrl2_reg);
  assign pinctl_next = full_active ? PINCTL_RESET :
                       (wr_pinctl ? reg_req.wdata : pinctl_reg);
  assign irq_en_next = full_active ? ENABLE_RESET :
                       (wr_irq_en ? reg_req.wdata : irq_en_reg);
  assign stat_en_next = full_active ? ENABLE_RESET :
                        (wr_stat_en ? reg_req.wdata : stat_en_reg);

  // Latched status: set on a rising status bit
  assign latched_set = status_in & ~status_prev_reg;
  // Clear policy follows the select bit; a read clears what it returned
  assign latched_clear = ctrl1.latched_clear_on_read_select ?
                         (rd_latch ? latched_bits : ZERO_WORD) :
                         (wr_latch ? reg_req.wdata : ZERO_WORD);

  sticky_bits #(
    .WIDTH(DATA_W)
  ) latched_inst (
    .clk(clk),
    .reset_n(reset_n),
    .set_bits(latched_set),
    .clear_bits(latched_clear),
    .force_clear(full_active),
    .held_bits(latched_bits)
  );

  // Identity word mirrors the boundary-scan code fields
  assign id_word = {REVISION_CODE, PART_CODE};

  // Read selection; unused offsets return zero
  assign read_word = (reg_req.addr == OFS_ID) ? id_word :
                     (reg_req.addr == OFS_CTRL1) ? ctrl1_reg :
                     (reg_req.addr == OFS_CTRL2) ? ctrl2_reg :
                     (reg_req.addr == OFS_PINCTL) ? pinctl_reg :
                     (reg_req.addr == OFS_IRQ_STAT) ? irq_source :
                     (reg_req.addr == OFS_IRQ_EN) ? irq_en_reg :
                     (reg_req.addr == OFS_STAT) ? status_in :
                     (reg_req.addr == OFS_STAT_LATCH) ? latched_bits :
                     (reg_req.addr == OFS_STAT_EN) ? stat_en_reg :
                     (reg_req.addr == OFS_PIN_READ) ? pin_word :
                     ZERO_WORD;
  // Data stand for one cycle only
  assign rdata_next = reg_req.rd ? read_word : ZERO_WORD;

  // Error insertion: each source keeps its own history
  // so flipping the select cannot fake an edge
  assign err_fire = ctrl1.error_insert_source_select ?
                    rising(pin_six_prev_reg, pin_six) :
                    rising(trig_prev_reg, ctrl1.manual_error_insert_trigger);

  // Performance monitor update source
  assign pm_fire = (ctrl1.pm_update_mode == PM_MODE_BIT) ?
                   rising(pm_bit_prev_reg, ctrl1.pm_update_bit) :
                   (ctrl1.pm_update_mode == PM_MODE_PIN) ?
                   rising(pm_pin_prev_reg, pm_pin) :
                   one_second_tick;

  // Interrupt: unmasked source level or unmasked latched status
  assign irq_next = (|(irq_source & irq_en_reg)) | (|(latched_bits & stat_en_reg));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl1_reg <= CTRL1_RESET;
      ctrl2_reg <= CTRL2_RESET;
      pinctl_reg <= PINCTL_RESET;
      irq_en_reg <= ENABLE_RESET;
      stat_en_reg <= ENABLE_RESET;
    end
    else
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      pinctl_reg <= pinctl_next;
      irq_en_reg <= irq_en_next;
      stat_en_reg <= stat_en_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_hold_reg <= HOLD_ZERO;
      full_hold_reg <= HOLD_ZERO;
    end
    else
    begin
      dp_hold_reg <= hold_next(ctrl1.datapath_soft_reset, dp_hold_reg);
      full_hold_reg <= hold_next(ctrl1.full_soft_reset, full_hold_reg);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trig_prev_reg <= 1'b0;
      pin_six_prev_reg <= 1'b0;
      pm_bit_prev_reg <= 1'b0;
      pm_pin_prev_reg <= 1'b0;
      status_prev_reg <= ZERO_WORD;
    end
    else
    begin
      trig_prev_reg <= ctrl1.manual_error_insert_trigger;
      pin_six_prev_reg <= pin_six;
      pm_bit_prev_reg <= ctrl1.pm_update_bit;
      pm_pin_prev_reg <= pm_pin;
      status_prev_reg <= status_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_pulse_reg <= 1'b0;
      pm_pulse_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= ZERO_WORD;
    end
    else
    begin
      err_pulse_reg <= err_fire;
      pm_pulse_reg <= pm_fire;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign reg_rdata = rdata_reg;
  assign control_two = ctrl2_reg;
  assign pin_control = pinctl_reg;
  assign latched_clear_on_read_select = ctrl1.latched_clear_on_read_select;
  assign global_error_insert = err_pulse_reg;
  assign pm_update = pm_pulse_reg;
  assign datapath_reset = dp_active;
  assign full_reset = full_active;
  assign revision_code_bits = REVISION_CODE;
  assign part_code_bits = PART_CODE;
  assign irq = irq_reg;

  // Pin is open-drain style: low when active, idle per select
  assign irq_pin_out = ~irq_reg;
  assign irq_pin_oe = irq_reg | ctrl1.irq_idle_drive_select;

endmodule

//--- tb/global_control_registers_asserts.sv
// Port checks for the global register bank
`timescale 1ns/10ps
module global_control_registers_asserts
  import global_regs_pkg::*;
#(
  parameter int PIN_COUNT = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire reg_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Pins and outputs
  input wire logic [PIN_COUNT-1:0] general_pin_in,
  input wire logic global_error_insert,
  input wire logic datapath_reset,
  input wire logic full_reset,
  input wire logic [3:0] revision_code_bits,
  input wire logic [11:0] part_code_bits,
  input wire logic irq,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Idle drive, trigger, source select as last written
  logic [2:0] shadow_reg;
  logic [4:0] full_cnt_reg;
  wire ctrl_wr = reg_req.wr && reg_req.addr == OFS_CTRL1 && !full_reset;
  wire mapped = reg_req.addr inside {OFS_ID, OFS_CTRL1, OFS_CTRL2, OFS_PINCTL, OFS_IRQ_STAT,
    OFS_IRQ_EN, OFS_STAT, OFS_STAT_LATCH, OFS_STAT_EN, OFS_PIN_READ};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shadow_reg <= 3'h0;
      full_cnt_reg <= 5'h00;
    end
    else
    begin
      if (full_reset)
        shadow_reg <= 3'h0;
      else if (ctrl_wr)
        shadow_reg <= {reg_req.wdata[14], reg_req.wdata[7], reg_req.wdata[6]};
      if (!full_reset)
        full_cnt_reg <= 5'h00;
      else if (full_cnt_reg != 5'h1f)
        full_cnt_reg <= full_cnt_reg + 5'h01;
    end
  end
  property p_irq_low;
    irq |-> irq_pin_oe && !irq_pin_out;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("irq pin not driven low");
  property p_idle_state;
    !irq && !full_reset && !$past(full_reset) |-> irq_pin_oe == shadow_reg[2] && irq_pin_out;
  endproperty
  a_idle_state: assert property (p_idle_state)
    else $error("irq pin idle state wrong");
  property p_id_read;
    reg_req.rd && reg_req.addr == OFS_ID |=> reg_rdata == {revision_code_bits, part_code_bits};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity read wrong");
  property p_unmapped;
    reg_req.rd && !mapped |=> reg_rdata == ZERO_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unused offset not zero");
  property p_rdata_idle;
    !reg_req.rd |=> reg_rdata == ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
  property p_manual;
    ctrl_wr && reg_req.wdata[7] && !reg_req.wdata[6] && !shadow_reg[1] |-> ##2 global_error_insert;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual insert missing");
  property p_gated;
    ctrl_wr && reg_req.wdata[7] && reg_req.wdata[6] && shadow_reg[0] && !shadow_reg[1]
      |-> ##2 !global_error_insert;
  endproperty
  a_gated: assert property (p_gated)
    else $error("insert while pin source selected");
  property p_pin;
    shadow_reg[0] && $rose(general_pin_in[GENERAL_PIN_SIX_IDX]) |-> ##[2:4] global_error_insert;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin insert missing");
  property p_full_hold;
    $fell(full_reset) |-> full_cnt_reg >= RESET_HOLD_CYCLES;
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("full reset too short");
  property p_full_dp;
    full_reset |-> datapath_reset;
  endproperty
  a_full_dp: assert property (p_full_dp)
    else $error("full reset without data path reset");
  c_insert: cover property (global_error_insert);
  c_irq: cover property (irq && !irq_pin_out);
  c_full: cover property ($fell(full_reset));
endmodule

bind global_control_registers global_control_registers_asserts #(.PIN_COUNT(PIN_COUNT)) chk_i (
  .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .general_pin_in(general_pin_in), .global_error_insert(global_error_insert),
  .datapath_reset(datapath_reset), .full_reset(full_reset),
  .revision_code_bits(revision_code_bits), .part_code_bits(part_code_bits),
  .irq(irq), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe)
);

//--- tb/test_global_control_registers.sv
// Self-checking bench for the global register bank
`timescale 1ns/10ps
module test_global_control_registers import global_regs_pkg::*;
;
  // Arbitrary identity values
  localparam logic [3:0] REV = 4'h3;
  localparam logic [11:0] PART = 12'h0c7;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic tick = 1'b0;
  reg_req_t req = '0;
  logic [DATA_W-1:0] irq_source = 16'h0000;
  logic [DATA_W-1:0] status_in = 16'h0000;
  logic [7:0] pins = 8'h00;
  logic [DATA_W-1:0] reg_rdata, control_two, pin_control;
  logic [3:0] rev_bits;
  logic [11:0] part_bits;
  logic clr_sel, ins, dp_rst, full_rst, irq, pin_out, pin_oe, pm_upd;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int inserts = 0;
  int pulses = 0;
  int base = 0;
  logic [ADDR_W-1:0] t_addr [10] = '{OFS_ID, OFS_CTRL2, OFS_PINCTL, OFS_IRQ_EN, OFS_STAT_EN,
    OFS_IRQ_STAT, OFS_STAT, OFS_STAT_LATCH, OFS_PIN_READ, 5'h06};
  logic [DATA_W-1:0] t_exp [10] = '{{REV, PART}, CTRL2_MASK, 16'hffff, 16'hffff, 16'hffff,
    ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD, ZERO_WORD};

  global_control_registers #(.REVISION_CODE(REV), .PART_CODE(PART)) global_control_registers_i (
    .clk(clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(reg_rdata),
    .irq_source(irq_source), .status_in(status_in), .one_second_tick(tick),
    .general_pin_in(pins), .control_two(control_two), .pin_control(pin_control),
    .latched_clear_on_read_select(clr_sel), .global_error_insert(ins), .pm_update(pm_upd),
    .datapath_reset(dp_rst), .full_reset(full_rst), .revision_code_bits(rev_bits),
    .part_code_bits(part_bits), .irq(irq), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe)
  );

  always #5 clk = ~clk;

  task automatic close_out();
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (ins === 1'b1)
      inserts++;
    if (pm_upd === 1'b1)
      pulses++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    check({rev_bits, part_bits}, {REV, PART});
    rd(OFS_CTRL1, CTRL1_RESET);
    check({15'h0000, dp_rst}, 16'h0001);
    for (int i = 1; i < 5; i++)
      rd(t_addr[i], ZERO_WORD);
    for (int i = 0; i < 10; i++)
    begin
      wr(t_addr[i], 16'hffff);
      rd(t_addr[i], t_exp[i]);
    end
    check(control_two & pin_control, CTRL2_MASK);
    base = inserts;
    wr(OFS_CTRL1, 16'hffbc);
    settle(3);
    check(16'(inserts - base), 16'h0001);
    rd(OFS_CTRL1, 16'h40bc);
    check({13'h0000, clr_sel, pin_oe, pin_out}, 16'h0007);
    base = inserts;
    wr(OFS_CTRL1, 16'h0080);
    // Register updates in this very time step; look once it has settled
    settle(0);
    check({15'h0000, pin_oe}, 16'h0000);
    wr(OFS_CTRL1, 16'h0000);
    wr(OFS_CTRL1, 16'h0080);
    settle(3);
    check(16'(inserts - base), 16'h0001);
    wr(OFS_CTRL1, 16'h0040);
    wr(OFS_CTRL1, 16'h00c0);
    settle(3);
    check(16'(inserts - base), 16'h0001);
    pins <= 8'h20;
    settle(6);
    check(16'(inserts - base), 16'h0002);
    rd(OFS_PIN_READ, 16'h0020);
    pins <= 8'h00;
    wr(OFS_CTRL1, 16'h0000);
    pins <= 8'h20;
    settle(6);
    check(16'(inserts - base), 16'h0002);
    irq_source <= 16'h0a5a;
    settle(2);
    rd(OFS_IRQ_STAT, 16'h0a5a);
    check({13'h0000, irq, pin_oe, pin_out}, 16'h0006);
    wr(OFS_IRQ_EN, 16'h0000);
    settle(2);
    check({13'h0000, irq, pin_oe, pin_out}, 16'h0001);
    irq_source <= 16'h0000;
    status_in <= 16'h0008;
    settle(3);
    rd(OFS_STAT, 16'h0008);
    rd(OFS_STAT_LATCH, 16'h0008);
    check({15'h0000, irq}, 16'h0001);
    wr(OFS_STAT_LATCH, 16'h0008);
    rd(OFS_STAT_LATCH, ZERO_WORD);
    wr(OFS_CTRL1, 16'h0004);
    status_in <= 16'h0018;
    settle(2);
    wr(OFS_STAT_LATCH, 16'hffff);
    rd(OFS_STAT_LATCH, 16'h0010);
    rd(OFS_STAT_LATCH, ZERO_WORD);
    status_in <= 16'h0000;
    wr(OFS_CTRL1, 16'h4001);
    settle(0);
    check({14'h0000, full_rst, dp_rst}, 16'h0003);
    wr(OFS_PINCTL, 16'h1234);
    rd(OFS_PINCTL, ZERO_WORD);
    wr(OFS_CTRL1, 16'h0000);
    settle(12);
    check({14'h0000, full_rst, dp_rst}, 16'h0001);
    rd(OFS_CTRL1, CTRL1_RESET);
    rd(OFS_CTRL2, ZERO_WORD);
    wr(OFS_CTRL1, 16'h0000);
    settle(2);
    check({15'h0000, dp_rst}, 16'h0000);
    wr(OFS_CTRL1, 16'h0002);
    wr(OFS_CTRL1, 16'h0000);
    settle(3);
    check({15'h0000, dp_rst}, 16'h0001);
    settle(10);
    check({15'h0000, dp_rst}, 16'h0000);
    // Monitor update: bit edge, then one second tick, then pin eight
    base = pulses;
    wr(OFS_CTRL1, 16'h0008);
    wr(OFS_CTRL1, 16'h0030);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    settle(3);
    check(16'(pulses - base), 16'h0002);
    wr(OFS_CTRL1, 16'h0010);
    pins <= 8'ha0;
    settle(5);
    check(16'(pulses - base), 16'h0003);
    close_out();
  end
endmodule
